// file: hdl/bdlu_core.sv
// execution datapath for decimal adjust, decrement, divide and loop-branch
`timescale 1ns/1ps
module bdlu_core (
    // clock and reset
    input  wire logic                        clock_i,
    input  wire logic                        rstn_i,
    // request from the instruction sequencer
    input  wire logic                        start_i,
    input  wire logic [7:0]                  opcode_i,
    input  wire logic [7:0]                  byte2_i,
    input  wire logic [7:0]                  byte3_i,
    input  wire logic [bdlu_pkg::PC_W-1:0]   pc_i,
    // operands and flags
    input  wire logic [bdlu_pkg::DATA_W-1:0] acc_i,
    input  wire logic [bdlu_pkg::DATA_W-1:0] b_i,
    input  wire logic [bdlu_pkg::DATA_W-1:0] operand_i,
    input  wire logic                        target_is_port_i,
    input  wire logic [bdlu_pkg::DATA_W-1:0] port_latch_i,
    input  wire logic                        cy_i,
    input  wire logic                        aux_carry_flag_i,
    // status
    output logic                             busy_o,
    output logic                             done_o,
    output logic                             illegal_o,
    // register results
    output logic [bdlu_pkg::DATA_W-1:0]      acc_o,
    output logic                             acc_we_o,
    output logic [bdlu_pkg::DATA_W-1:0]      b_o,
    output logic                             b_we_o,
    // memory-side result
    output logic [bdlu_pkg::DATA_W-1:0]      mem_data_o,
    output logic                             mem_we_o,
    output bdlu_pkg::bdlu_mode_t             mem_mode_o,
    output logic [7:0]                       mem_sel_o,
    // flags and program counter
    output logic                             cy_o,
    output logic                             cy_we_o,
    output logic                             overflow_flag_o,
    output logic                             ov_we_o,
    output logic [bdlu_pkg::PC_W-1:0]        program_counter_o,
    output logic                             pc_we_o
);
    import bdlu_pkg::*;

    // ****************************************
    // arithmetic helpers
    // ****************************************
    function automatic logic [8:0] bdlu_da_fix(input logic [7:0] a, input logic c,
                                               input logic ac);
        logic [8:0] t;
        logic       c1;
        t = {1'b0, a};
        if (a[3:0] > BCD_MAX || ac) begin
            t = t + {5'h00, BCD_FIX};
        end
        c1 = c | t[8];
        if (t[7:4] > BCD_MAX || c1) begin
            t = {1'b0, t[7:0]} + {1'b0, BCD_FIX, 4'h0};
        end
        return {c1 | t[8], t[7:0]};
    endfunction : bdlu_da_fix

    // one restoring step: {quotient bit, new remainder}
    function automatic logic [8:0] bdlu_div_step(input logic [7:0] r, input logic nb,
                                                 input logic [7:0] d);
        logic [8:0] t;
        t = {r, nb};
        if (t >= {1'b0, d}) begin
            return {1'b1, 8'(t - {1'b0, d})};
        end
        return {1'b0, t[7:0]};
    endfunction : bdlu_div_step

    // ****************************************
    // decode
    // ****************************************
    typedef enum logic {ST_IDLE, ST_BUSY} bdlu_state_t;
    bdlu_state_t state;
    logic [2:0]  cnt;
    logic        take;
    logic        is_da, is_dec_a, is_dec_reg, is_dec_dir, is_dec_ind, is_div;
    logic        is_loop_reg, is_loop_dir, is_loop, is_mem, known;
    logic [2:0]  cycles;

    assign take        = start_i && (state == ST_IDLE);
    assign is_da       = (opcode_i == OP_DA);
    assign is_dec_a    = (opcode_i == OP_DEC_A);
    assign is_dec_dir  = (opcode_i == OP_DEC_DIR);
    assign is_dec_ind  = (opcode_i[7:1] == OP_DEC_IND);
    assign is_dec_reg  = (opcode_i[7:3] == OP_DEC_REG);
    assign is_div      = (opcode_i == OP_DIV);
    assign is_loop_reg = (opcode_i[7:3] == OP_LOOP_REG);
    assign is_loop_dir = (opcode_i == OP_LOOP_DIR);
    assign is_loop     = is_loop_reg || is_loop_dir;
    assign is_mem      = is_dec_reg || is_dec_dir || is_dec_ind || is_loop;
    assign known       = is_da || is_dec_a || is_mem || is_div;
    assign cycles      = is_div ? CYC_DIV : (is_loop ? CYC_LOOP : CYC_ONE);

    // ****************************************
    // datapath values
    // ****************************************
    logic [7:0]  src, dec_val, rel, div_d, src_quo, src_rem, src_d;
    logic [8:0]  da_res, s1, s2;
    logic [15:0] pc_adv, pc_target;
    logic        pend_div;

    // a port read here would see pins, so the latch copy is used
    assign src       = is_dec_a ? acc_i : (target_is_port_i ? port_latch_i : operand_i);
    assign dec_val   = src - 8'h01;
    assign da_res    = bdlu_da_fix(acc_i, cy_i, aux_carry_flag_i);
    assign rel       = is_loop_dir ? byte3_i : byte2_i;
    assign pc_adv    = pc_i + (is_loop_dir ? LEN_LOOP_DIR : LEN_LOOP_REG);
    assign pc_target = pc_adv + {{8{rel[7]}}, rel};
    // divide reuses the result registers as working quotient and remainder
    assign src_quo   = (state == ST_IDLE) ? acc_i : acc_o;
    assign src_rem   = (state == ST_IDLE) ? 8'h00 : b_o;
    assign src_d     = (state == ST_IDLE) ? b_i : div_d;
    assign s1        = bdlu_div_step(src_rem, src_quo[7], src_d);
    assign s2        = bdlu_div_step(s1[7:0], src_quo[6], src_d);

    // ****************************************
    // sequencing
    // ****************************************
    logic fin;
    assign fin    = (take && cycles == CYC_ONE) || (state == ST_BUSY && cnt == 3'h0);
    assign busy_o = (state == ST_BUSY);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            cnt   <= 3'h0;
        end else if (take && cycles != CYC_ONE) begin
            state <= ST_BUSY;
            cnt   <= cycles - CYC_BIAS;
        end else if (state == ST_BUSY) begin
            if (cnt == 3'h0) begin
                state <= ST_IDLE;
            end else begin
                cnt <= cnt - 3'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= fin;
        end
    end

    // ****************************************
    // write enables, raised only with done
    // ****************************************
    logic pend_acc, pend_b, pend_mem, pend_cy, pend_ov, pend_pc, pend_bad;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {pend_acc, pend_b, pend_mem, pend_cy} <= 4'h0;
            {pend_ov, pend_pc, pend_bad, pend_div} <= 4'h0;
        end else if (take) begin
            pend_acc <= is_da || is_dec_a || is_div;
            pend_b   <= is_div;
            pend_mem <= is_mem;
            pend_cy  <= is_da || is_div;
            pend_ov  <= is_div;
            pend_pc  <= is_loop;
            pend_bad <= !known;
            pend_div <= is_div;
        end
    end

    assign acc_we_o  = done_o && pend_acc;
    assign b_we_o    = done_o && pend_b;
    assign mem_we_o  = done_o && pend_mem;
    assign cy_we_o   = done_o && pend_cy;
    assign ov_we_o   = done_o && pend_ov;
    assign pc_we_o   = done_o && pend_pc;
    assign illegal_o = done_o && pend_bad;

    // ****************************************
    // accumulator and second register
    // ****************************************
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_o <= 8'h00;
            b_o   <= 8'h00;
            div_d <= 8'h00;
        end else if ((take && is_div) || (busy_o && pend_div)) begin
            acc_o <= {src_quo[5:0], s1[8], s2[8]};
            b_o   <= s2[7:0];
            if (take) begin
                div_d <= b_i;
            end
        end else if (take && is_da) begin
            acc_o <= da_res[7:0];
        end else if (take && is_dec_a) begin
            acc_o <= dec_val;
        end
    end

    // ****************************************
    // memory result, flags, program counter
    // ****************************************
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_data_o <= 8'h00;
            mem_mode_o <= MODE_REG;
            mem_sel_o  <= 8'h00;
        end else if (take && is_mem) begin
            mem_data_o <= dec_val;
            if (is_dec_dir || is_loop_dir) begin
                mem_mode_o <= MODE_DIRECT;
                mem_sel_o  <= byte2_i;
            end else if (is_dec_ind) begin
                mem_mode_o <= MODE_INDIRECT;
                mem_sel_o  <= 8'(opcode_i[0]);
            end else begin
                mem_mode_o <= MODE_REG;
                mem_sel_o  <= 8'(opcode_i[2:0]);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cy_o              <= 1'b0;
            overflow_flag_o   <= 1'b0;
            program_counter_o <= 16'h0000;
        end else if (take) begin
            cy_o              <= is_da && da_res[8];
            overflow_flag_o   <= is_div && (b_i == 8'h00);
            program_counter_o <= (dec_val != 8'h00) ? pc_target : pc_adv;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking bdlu_cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence s_take_div;
        take && is_div;
    endsequence
    sequence s_take_loop;
        take && is_loop;
    endsequence

    a_da_low_fix: assert property (take && is_da && (acc_i[3:0] > BCD_MAX)
        && acc_i[7:4] < 4'h8 && !cy_i |-> ##1 acc_o[3:0] == 4'($past(acc_i[3:0]) + BCD_FIX))
        else $error("decimal adjust low nibble wrong");
    a_da_carry_out: assert property (take && is_da && acc_i >= 8'ha0
        |-> ##1 cy_o && cy_we_o) else $error("decimal adjust carry not set");
    a_da_carry_keep: assert property (take && is_da && cy_i |-> ##1 cy_o)
        else $error("decimal adjust cleared carry");
    a_dec_no_flags: assert property (take && is_dec_a |-> ##1 done_o
        && acc_o == 8'($past(acc_i) - 8'h01) && !cy_we_o && !ov_we_o)
        else $error("decrement result or flags wrong");
    a_dec_reg_mode: assert property (take && is_dec_reg |-> ##1 mem_we_o
        && mem_mode_o == MODE_REG && mem_sel_o[2:0] == $past(opcode_i[2:0]))
        else $error("register decrement target wrong");
    a_port_latch: assert property (take && is_dec_dir && target_is_port_i
        |-> ##1 mem_data_o == 8'($past(port_latch_i) - 8'h01))
        else $error("port decrement read pins");
    a_div_result: assert property (s_take_div and (b_i != 8'h00) |->
        ##1 !done_o [*3] ##1 (acc_we_o && b_we_o && !cy_o && !overflow_flag_o
        && acc_o == $past(acc_i, 4) / $past(b_i, 4)
        && b_o == $past(acc_i, 4) % $past(b_i, 4)))
        else $error("divide result or timing wrong");
    a_div_zero: assert property (s_take_div and (b_i == 8'h00)
        |-> ##4 ov_we_o && overflow_flag_o && !cy_o)
        else $error("divide by zero flags wrong");
    a_loop_two: assert property (s_take_loop |-> ##1 !done_o ##1 (done_o
        && pc_we_o && !cy_we_o)) else $error("loop cycle count wrong");
    a_loop_branch: assert property (s_take_loop and is_loop_reg
        and (operand_i != 8'h01) and !target_is_port_i |-> ##2 program_counter_o
        == 16'($past(pc_i, 2) + LEN_LOOP_REG + {{8{$past(byte2_i[7], 2)}}, $past(byte2_i, 2)}))
        else $error("loop branch target wrong");
    a_loop_direct: assert property (s_take_loop and is_loop_dir
        |-> ##2 mem_mode_o == MODE_DIRECT && mem_sel_o == $past(byte2_i, 2))
        else $error("direct loop target wrong");

endmodule : bdlu_core

// file: hdl/bdlu_pkg.sv
// constants shared by the decimal adjust, decrement, divide and loop datapath
package bdlu_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PC_W   = 16;

    // ****************************************
    // opcodes, full bytes and prefixes
    // ****************************************
    localparam logic [7:0] OP_DA       = 8'hd4;
    localparam logic [7:0] OP_DEC_A    = 8'h14;
    localparam logic [7:0] OP_DEC_DIR  = 8'h15;
    localparam logic [6:0] OP_DEC_IND  = 7'h0b;  // 0001011i
    localparam logic [4:0] OP_DEC_REG  = 5'h03;  // 00011rrr
    localparam logic [7:0] OP_DIV      = 8'h84;
    localparam logic [4:0] OP_LOOP_REG = 5'h1b;  // 11011rrr
    localparam logic [7:0] OP_LOOP_DIR = 8'hd5;

    // ****************************************
    // decimal adjust figures
    // ****************************************
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;

    // ****************************************
    // machine cycles per instruction and lengths
    // ****************************************
    localparam logic [2:0]  CYC_ONE      = 3'h1;
    localparam logic [2:0]  CYC_LOOP     = 3'h2;
    localparam logic [2:0]  CYC_DIV      = 3'h4;
    localparam logic [2:0]  CYC_BIAS     = 3'h2;
    localparam logic [15:0] LEN_LOOP_REG = 16'h0002;
    localparam logic [15:0] LEN_LOOP_DIR = 16'h0003;

    // ****************************************
    // memory-side operand addressing
    // ****************************************
    typedef enum logic [1:0] {MODE_REG, MODE_DIRECT, MODE_INDIRECT} bdlu_mode_t;

endpackage : bdlu_pkg

// file: verification/bdlu_mem_model.sv
// partner model: working registers, direct and indirect bytes behind the datapath
`timescale 1ns/1ps
module bdlu_mem_model (
    // clock
    input  wire logic                 clock_i,
    // write-back from the datapath
    input  wire logic                 we_i,
    input  wire bdlu_pkg::bdlu_mode_t mode_i,
    input  wire logic [7:0]           sel_i,
    input  wire logic [7:0]           data_i,
    // operand fetch on behalf of the sequencer
    input  wire bdlu_pkg::bdlu_mode_t rd_mode_i,
    input  wire logic [7:0]           rd_sel_i,
    output logic [7:0]                rd_data_o
);
    import bdlu_pkg::*;
    // one flat array; mode picks the space so a register and a direct byte never alias
    logic [7:0] store [0:1023];
    initial begin
        for (int i = 0; i < 1024; i++) begin
            store[i] = 8'h00;
        end
    end
    // plain always: the bench preloads this array directly between transfers
    always @(posedge clock_i) begin
        if (we_i) begin
            store[{mode_i, sel_i}] <= data_i;
        end
    end
    assign rd_data_o = store[{rd_mode_i, rd_sel_i}];
endmodule : bdlu_mem_model

// file: verification/tb_top.sv
// self-checking bench for the decimal adjust, decrement, divide and loop datapath
`timescale 1ns/1ps
module tb_top;
    import bdlu_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic        clock_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        start_i = 1'b0;
    logic [7:0]  opcode_i = 8'h00, byte2_i = 8'h00, byte3_i = 8'h00, rd_sel = 8'h00;
    logic [15:0] pc_i = 16'h0000;
    logic [7:0]  acc_i = 8'h00, b_i = 8'h00, port_latch_i = 8'h00, operand_i, rd_data;
    logic        target_is_port_i = 1'b0, cy_i = 1'b0, aux_carry_flag_i = 1'b0;
    logic        busy_o, done_o, illegal_o, acc_we_o, b_we_o, mem_we_o;
    logic        cy_o, cy_we_o, overflow_flag_o, ov_we_o, pc_we_o;
    logic [7:0]  acc_o, b_o, mem_data_o, mem_sel_o;
    logic [15:0] program_counter_o;
    bdlu_mode_t  mem_mode_o, rd_mode = MODE_REG;
    int          n_fail = 0;
    int          n_tests = 0;
    always #20 clock_i = ~clock_i;
    // pins differ from the latch so a port read from the wrong source shows
    assign operand_i = target_is_port_i ? 8'h55 : rd_data;
    bdlu_core dut (.clock_i, .rstn_i, .start_i, .opcode_i, .byte2_i, .byte3_i, .pc_i,
        .acc_i, .b_i, .operand_i, .target_is_port_i, .port_latch_i, .cy_i, .aux_carry_flag_i,
        .busy_o, .done_o, .illegal_o, .acc_o, .acc_we_o, .b_o, .b_we_o, .mem_data_o,
        .mem_we_o, .mem_mode_o, .mem_sel_o, .cy_o, .cy_we_o, .overflow_flag_o, .ov_we_o,
        .program_counter_o, .pc_we_o);
    bdlu_mem_model mem (.clock_i, .we_i(mem_we_o), .mode_i(mem_mode_o), .sel_i(mem_sel_o),
        .data_i(mem_data_o), .rd_mode_i(rd_mode), .rd_sel_i(rd_sel), .rd_data_o(rd_data));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    // poke re-requests while busy, which must be ignored
    task automatic issue(input logic [7:0] op, b2, b3, input int ncyc, input bit poke);
        int n;
        n = 0;
        opcode_i = op;
        byte2_i = b2;
        byte3_i = b3;
        start_i = 1'b1;
        @(posedge clock_i);
        #1;
        start_i = 1'b0;
        chk(16'(busy_o), 16'(ncyc > 1), "busy");
        while (done_o !== 1'b1 && n < 10) begin
            @(posedge clock_i);
            #1;
            n++;
            start_i = poke && n == 1;
        end
        chk(16'(n + 1), 16'(ncyc), "cycles");
    endtask : issue
    task automatic da(input logic [7:0] a, input bit ac, cy, input logic [7:0] ea, input bit ec);
        acc_i = a;
        aux_carry_flag_i = ac;
        cy_i = cy;
        issue(OP_DA, 8'h00, 8'h00, 1, 1'b0);
        chk(acc_o, ea, "da acc");
        chk({acc_we_o, cy_we_o, ov_we_o}, 3'b110, "da writes");
        chk(cy_o, ec, "da carry");
    endtask : da
    task automatic mem_op(input logic [7:0] op, b2, b3, input bdlu_mode_t md,
                          input logic [7:0] sel, val, input bit port);
        logic [7:0]  res, rel;
        logic [15:0] tgt;
        bit          lp;
        lp = op[7:3] == OP_LOOP_REG || op == OP_LOOP_DIR;
        rel = (op == OP_LOOP_DIR) ? b3 : b2;
        res = val - 8'h01;
        tgt = pc_i + ((op == OP_LOOP_DIR) ? LEN_LOOP_DIR : LEN_LOOP_REG);
        tgt = tgt + ((res != 8'h00) ? {{8{rel[7]}}, rel} : 16'h0000);
        rd_mode = md;
        rd_sel = sel;
        mem.store[{md, sel}] = val;
        target_is_port_i = port;
        port_latch_i = val;
        issue(op, b2, b3, lp ? 2 : 1, 1'b0);
        chk(mem_data_o, res, "new value");
        chk({mem_we_o, acc_we_o, cy_we_o, ov_we_o, pc_we_o}, {4'b1000, lp}, "writes");
        chk(mem_sel_o, sel, "select");
        chk(16'(mem_mode_o), 16'(md), "mode");
        if (lp) chk(program_counter_o, tgt, "target");
    endtask : mem_op
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_da();
        da(8'hbe, 1'b0, 1'b0, 8'h24, 1'b1);
        da(8'hc9, 1'b0, 1'b0, 8'h29, 1'b1);
        da(8'h56, 1'b0, 1'b1, 8'hb6, 1'b1);
        da(8'h19, 1'b1, 1'b0, 8'h1f, 1'b0);
        da(8'h3c, 1'b0, 1'b0, 8'h42, 1'b0);
        da(8'h9a, 1'b0, 1'b0, 8'h00, 1'b1);
    endtask : t_da
    task automatic t_dec();
        cy_i = 1'b1;
        acc_i = 8'h00;
        issue(OP_DEC_A, 8'h00, 8'h00, 1, 1'b0);
        chk(acc_o, 8'hff, "dec acc wrap");
        chk({acc_we_o, cy_we_o, ov_we_o, mem_we_o}, 4'b1000, "dec acc writes");
        for (int r = 0; r < 8; r++) begin
            mem_op({OP_DEC_REG, 3'(r)}, 8'h00, 8'h00, MODE_REG, 8'(r), 8'(8'h10 + r), 1'b0);
        end
        mem_op(OP_DEC_DIR, 8'h7f, 8'h00, MODE_DIRECT, 8'h7f, 8'h00, 1'b0);
        mem_op(OP_DEC_DIR, 8'h90, 8'h00, MODE_DIRECT, 8'h90, 8'h3c, 1'b1);
        mem_op({OP_DEC_IND, 1'b0}, 8'h00, 8'h00, MODE_INDIRECT, 8'h00, 8'h40, 1'b0);
        mem_op({OP_DEC_IND, 1'b1}, 8'h00, 8'h00, MODE_INDIRECT, 8'h01, 8'h80, 1'b0);
    endtask : t_dec
    task automatic t_div();
        cy_i = 1'b1;
        acc_i = 8'hfb;
        b_i = 8'h12;
        issue(OP_DIV, 8'h00, 8'h00, 4, 1'b1);
        chk({acc_o, b_o}, 16'h0d11, "quotient remainder");
        chk({acc_we_o, b_we_o, cy_we_o, cy_o, ov_we_o, overflow_flag_o}, 6'h3a, "div flags");
        acc_i = 8'h07;
        b_i = 8'h09;
        issue(OP_DIV, 8'h00, 8'h00, 4, 1'b0);
        chk({acc_o, b_o}, 16'h0007, "small quotient");
        b_i = 8'h00;
        issue(OP_DIV, 8'h00, 8'h00, 4, 1'b0);
        chk({cy_we_o, cy_o, ov_we_o, overflow_flag_o}, 4'b1011, "zero divisor");
    endtask : t_div
    task automatic t_loop();
        pc_i = 16'h1000;
        mem_op({OP_LOOP_REG, 3'h3}, 8'hfe, 8'h00, MODE_REG, 8'h03, 8'h05, 1'b0);
        mem_op({OP_LOOP_REG, 3'h3}, 8'hfe, 8'h00, MODE_REG, 8'h03, 8'h01, 1'b0);
        mem_op({OP_LOOP_REG, 3'h7}, 8'h7f, 8'h00, MODE_REG, 8'h07, 8'h00, 1'b0);
        pc_i = 16'h2000;
        mem_op(OP_LOOP_DIR, 8'h40, 8'h10, MODE_DIRECT, 8'h40, 8'h70, 1'b0);
        mem_op(OP_LOOP_DIR, 8'h90, 8'h80, MODE_DIRECT, 8'h90, 8'h02, 1'b1);
    endtask : t_loop
    task automatic t_misc();
        acc_i = 8'h01;
        opcode_i = OP_DEC_A;
        start_i = 1'b1;
        @(posedge clock_i);
        #1;
        acc_i = 8'h00;
        chk({done_o, acc_o}, 9'h100, "first of pair");
        @(posedge clock_i);
        #1;
        start_i = 1'b0;
        chk({done_o, acc_o}, 9'h1ff, "second of pair");
        @(posedge clock_i);
        #1;
        issue(8'ha5, 8'h00, 8'h00, 1, 1'b0);
        chk({illegal_o, acc_we_o, b_we_o, mem_we_o, cy_we_o, pc_we_o}, 6'h20, "unknown op");
    endtask : t_misc
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (4) @(posedge clock_i);
        #1;
        rstn_i = 1'b1;
        t_da();
        t_dec();
        t_div();
        t_loop();
        t_misc();
        end_of_test();
    end
    initial begin
        // whole run is about fifty cycles; this leaves ample slack
        #100000;
        n_fail++;
        end_of_test();
    end
endmodule : tb_top
